// >>> logic/timer2_auto_reload.sv
// Auto-reload timer with AXI4-Lite register access and interrupts
`timescale 1ns/100ps
`include "timer2_consts.svh"
module timer2_auto_reload #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_ext_osc,
  input  wire logic [ADDR_WIDTH-1:0] i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output      logic                  o_s_axi_awready,
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output      logic                  o_s_axi_wready,
  output      logic [1:0]            o_s_axi_bresp,
  output      logic                  o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output      logic                  o_s_axi_arready,
  output      logic [31:0]           o_s_axi_rdata,
  output      logic [1:0]            o_s_axi_rresp,
  output      logic                  o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  output      logic                  o_timer_irq,
  output      logic                  o_irq
);
  import timer2_pkg::*;

  if (ADDR_WIDTH < 6 || ADDR_WIDTH > 8) begin : g_bad_width
    $error("ADDR_WIDTH must be 6 to 8");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]     rst_sync;
  logic           rst_n;
  timer2_tick_if  tick_bus ();

  byte_t          count_low_byte;
  byte_t          count_high_byte;
  byte_t          reload_low_byte;
  byte_t          reload_high_byte;
  logic           high_overflow_flag;
  logic           low_overflow_flag;
  logic           low_overflow_irq_enable;
  logic           frame_capture_select;
  logic           split_mode_select;
  logic           run_control;
  logic           external_clock_select;
  logic           high_byte_system_clock_select;
  logic           low_byte_system_clock_select;
  logic           timer_irq_enable;
  status_t        irq_status;
  status_t        irq_mask;

  logic [7:0]     aw_addr;
  logic [7:0]     wr_data;
  logic           wr_lane0;
  logic           aw_held;
  logic           w_held;
  logic           do_write;
  logic           do_read;
  logic [7:0]     rd_addr;

  clk_src_t       low_src;
  clk_src_t       high_src;
  logic           low_tick;
  logic           high_tick;
  logic           low_step;
  logic           high_step;
  logic           low_wrap;
  logic           high_wrap;
  logic           full_wrap;
  logic           set_high_flag;
  logic           set_low_flag;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  timer2_prescaler u_prescaler (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_ext_osc (i_ext_osc),
    .tick      (tick_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock source per byte; in 16-bit mode the low-byte select drives both
  assign low_src   = low_byte_system_clock_select ? SRC_SYS
                     : external_clock_select ? SRC_EXT8
                     : SRC_DIV12;
  assign high_src  = high_byte_system_clock_select ? SRC_SYS
                     : external_clock_select ? SRC_EXT8
                     : SRC_DIV12;
  assign low_tick  = (low_src == SRC_SYS) ||
                     (low_src == SRC_EXT8 && tick_bus.tick_ext8) ||
                     (low_src == SRC_DIV12 && tick_bus.tick_div12);
  assign high_tick = (high_src == SRC_SYS) ||
                     (high_src == SRC_EXT8 && tick_bus.tick_ext8) ||
                     (high_src == SRC_DIV12 && tick_bus.tick_div12);

  ////////////////////////////////////////////////////////////////////////
  // Counting steps and wraps
  always_comb begin
    if (split_mode_select) begin
      low_step  = low_tick;
      high_step = run_control && high_tick;
    end else begin
      low_step  = run_control && low_tick;
      high_step = low_step && (count_low_byte == 8'hff);
    end
  end

  assign low_wrap  = low_step && (count_low_byte == 8'hff);
  assign high_wrap = high_step && (count_high_byte == 8'hff);
  assign full_wrap = !split_mode_select && low_wrap &&
                     (count_high_byte == 8'hff);
  assign set_high_flag = split_mode_select ? high_wrap
                                           : full_wrap;
  assign set_low_flag  = low_wrap;

  ////////////////////////////////////////////////////////////////////////
  // Bus write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !o_s_axi_bvalid;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      wr_data         <= 8'h00;
      wr_lane0        <= 1'b0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `T2_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held         <= 1'b1;
        aw_addr         <= 8'(i_s_axi_awaddr);
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held         <= 1'b1;
        wr_data        <= i_s_axi_wdata[7:0];
        wr_lane0       <= i_s_axi_wstrb[0];
        o_s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (aw_addr > `T2_MASK_ADDR || aw_addr[1:0] != 2'h0)
                          ? `T2_RESP_SLVERR : `T2_RESP_OKAY;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        aw_held         <= 1'b0;
        w_held          <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_overflow_irq_enable <= 1'b0;
      frame_capture_select    <= 1'b0;
      split_mode_select       <= 1'b0;
      run_control             <= 1'b0;
      external_clock_select   <= 1'b0;
      high_byte_system_clock_select <= 1'b0;
      low_byte_system_clock_select  <= 1'b0;
      timer_irq_enable        <= 1'b0;
      reload_low_byte         <= `T2_BYTE_RESET;
      reload_high_byte        <= `T2_BYTE_RESET;
      irq_mask                <= `T2_STATUS_RESET;
    end else if (do_write && wr_lane0) begin
      if (aw_addr == `T2_CTRL_ADDR) begin
        low_overflow_irq_enable <= wr_data[`T2_LO_IRQ_EN_BIT];
        frame_capture_select    <= wr_data[`T2_FRAME_BIT];
        split_mode_select       <= wr_data[`T2_SPLIT_BIT];
        run_control             <= wr_data[`T2_RUN_BIT];
        external_clock_select   <= wr_data[`T2_EXT_SEL_BIT];
      end else if (aw_addr == `T2_CKSEL_ADDR) begin
        high_byte_system_clock_select <= wr_data[`T2_HI_SYS_BIT];
        low_byte_system_clock_select  <= wr_data[`T2_LO_SYS_BIT];
      end else if (aw_addr == `T2_RLD_LO_ADDR) begin
        reload_low_byte <= wr_data;
      end else if (aw_addr == `T2_RLD_HI_ADDR) begin
        reload_high_byte <= wr_data;
      end else if (aw_addr == `T2_IRQ_EN_ADDR) begin
        timer_irq_enable <= wr_data[`T2_TIMER_IE_BIT];
      end else if (aw_addr == `T2_MASK_ADDR) begin
        irq_mask <= wr_data[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter bytes; a software write to a byte wins over its step
  // Frame capture mode is not served: bytes then wrap to zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_byte <= `T2_BYTE_RESET;
    end else if (do_write && wr_lane0 && aw_addr == `T2_CNT_LO_ADDR) begin
      count_low_byte <= wr_data;
    end else if (low_wrap) begin
      if (frame_capture_select) begin
        count_low_byte <= 8'h00;
      end else if (split_mode_select || full_wrap) begin
        count_low_byte <= reload_low_byte;
      end else begin
        count_low_byte <= 8'h00;
      end
    end else if (low_step) begin
      count_low_byte <= count_low_byte + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_high_byte <= `T2_BYTE_RESET;
    end else if (do_write && wr_lane0 && aw_addr == `T2_CNT_HI_ADDR) begin
      count_high_byte <= wr_data;
    end else if (high_wrap) begin
      count_high_byte <= frame_capture_select ? 8'h00
                         : reload_high_byte;
    end else if (high_step) begin
      count_high_byte <= count_high_byte + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overflow flags: hardware set beats a software clear
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag  <= 1'b0;
    end else begin
      if (set_high_flag) begin
        high_overflow_flag <= 1'b1;
      end else if (do_write && wr_lane0 && aw_addr == `T2_CTRL_ADDR) begin
        high_overflow_flag <= wr_data[`T2_HI_FLAG_BIT];
      end
      if (set_low_flag) begin
        low_overflow_flag <= 1'b1;
      end else if (do_write && wr_lane0 && aw_addr == `T2_CTRL_ADDR) begin
        low_overflow_flag <= wr_data[`T2_LO_FLAG_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU interrupt request follows the high flag, and the low flag only while its own enable is set, under the timer enable
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_timer_irq <= 1'b0;
    end else begin
      o_timer_irq <= timer_irq_enable &&
                     (high_overflow_flag ||
                      (low_overflow_irq_enable &&
                       low_overflow_flag));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus read channel
  assign do_read = i_s_axi_arvalid && o_s_axi_arready;
  assign rd_addr = 8'(i_s_axi_araddr);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= `T2_RESP_OKAY;
    end else if (do_read) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rresp   <= `T2_RESP_OKAY;
      o_s_axi_rdata   <= 32'h0000_0000;
      if (rd_addr == `T2_CTRL_ADDR) begin
        o_s_axi_rdata[7:0] <= {high_overflow_flag, low_overflow_flag,
                               low_overflow_irq_enable,
                               frame_capture_select, split_mode_select,
                               run_control, 1'b0,
                               external_clock_select};
      end else if (rd_addr == `T2_CKSEL_ADDR) begin
        o_s_axi_rdata[`T2_HI_SYS_BIT] <= high_byte_system_clock_select;
        o_s_axi_rdata[`T2_LO_SYS_BIT] <= low_byte_system_clock_select;
      end else if (rd_addr == `T2_CNT_LO_ADDR) begin
        o_s_axi_rdata[7:0] <= count_low_byte;
      end else if (rd_addr == `T2_CNT_HI_ADDR) begin
        o_s_axi_rdata[7:0] <= count_high_byte;
      end else if (rd_addr == `T2_RLD_LO_ADDR) begin
        o_s_axi_rdata[7:0] <= reload_low_byte;
      end else if (rd_addr == `T2_RLD_HI_ADDR) begin
        o_s_axi_rdata[7:0] <= reload_high_byte;
      end else if (rd_addr == `T2_IRQ_EN_ADDR) begin
        o_s_axi_rdata[`T2_TIMER_IE_BIT] <= timer_irq_enable;
      end else if (rd_addr == `T2_STATUS_ADDR) begin
        o_s_axi_rdata[1:0] <= irq_status;
      end else if (rd_addr == `T2_MASK_ADDR) begin
        o_s_axi_rdata[1:0] <= irq_mask;
      end else begin
        o_s_axi_rresp <= `T2_RESP_SLVERR;
      end
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by read; a new event in that cycle survives
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `T2_STATUS_RESET;
    end else begin
      irq_status <= ((do_read && rd_addr == `T2_STATUS_ADDR)
                     ? `T2_STATUS_RESET : irq_status)
                    | {set_low_flag, set_high_flag};
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end
endmodule // timer2_auto_reload

// >>> logic/timer2_consts.svh
// Offsets, field positions, reset values and counts for the auto-reload timer
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// Register byte addresses (AXI4-Lite, one aligned word each)
`define T2_CTRL_ADDR      8'h00
`define T2_CKSEL_ADDR     8'h04
`define T2_CNT_LO_ADDR    8'h08
`define T2_CNT_HI_ADDR    8'h0c
`define T2_RLD_LO_ADDR    8'h10
`define T2_RLD_HI_ADDR    8'h14
`define T2_IRQ_EN_ADDR    8'h18
`define T2_STATUS_ADDR    8'h1c
`define T2_MASK_ADDR      8'h20

// Control register field positions
`define T2_HI_FLAG_BIT    7
`define T2_LO_FLAG_BIT    6
`define T2_LO_IRQ_EN_BIT  5
`define T2_FRAME_BIT      4
`define T2_SPLIT_BIT      3
`define T2_RUN_BIT        2
`define T2_EXT_SEL_BIT    0

// Clock select register field positions
`define T2_HI_SYS_BIT     5
`define T2_LO_SYS_BIT     4

// Timer interrupt enable register field
`define T2_TIMER_IE_BIT   0

// Sticky status / mask field positions
`define T2_ST_HI_BIT      0
`define T2_ST_LO_BIT      1

// Reset values
`define T2_BYTE_RESET     8'h00
`define T2_STATUS_RESET   2'h0

// Clock dividers
`define T2_SYS_DIV        4'hc
`define T2_EXT_DIV        4'h8

// Bus answers
`define T2_RESP_OKAY      2'h0
`define T2_RESP_SLVERR    2'h2

`endif

// >>> logic/timer2_pkg.sv
// Types shared by the auto-reload timer modules
package timer2_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [1:0]  status_t;

  typedef enum logic [2:0] {
    SRC_DIV12 = 3'b001,
    SRC_EXT8  = 3'b010,
    SRC_SYS   = 3'b100
  } clk_src_t;

endpackage

// >>> logic/timer2_tick_if.sv
// Tick strobes passed from the prescaler to the counter logic
`timescale 1ns/100ps
interface timer2_tick_if;
  logic tick_div12;
  logic tick_ext8;

  modport src (output tick_div12, output tick_ext8);
  modport dst (input  tick_div12, input  tick_ext8);
endinterface

// >>> logic/timer2_prescaler.sv
// System clock /12 and synchronised external oscillator /8 tick strobes
`timescale 1ns/100ps
`include "timer2_consts.svh"
module timer2_prescaler (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ext_osc,
  timer2_tick_if.src tick
);
  import timer2_pkg::*;

  logic [3:0] sys_count;
  logic [2:0] ext_sync;
  logic [3:0] ext_count;

  ////////////////////////////////////////////////////////////////////////
  // Divide system clock by 12
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys_count       <= 4'h0;
      tick.tick_div12 <= 1'b0;
    end else if (sys_count == `T2_SYS_DIV - 4'h1) begin
      sys_count       <= 4'h0;
      tick.tick_div12 <= 1'b1;
    end else begin
      sys_count       <= sys_count + 4'h1;
      tick.tick_div12 <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two flops before use; the third stage only feeds edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], i_ext_osc};
    end
  end

  // Oscillator must stay below half the system clock or edges are lost
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_count      <= 4'h0;
      tick.tick_ext8 <= 1'b0;
    end else if (ext_sync[1] && !ext_sync[2]) begin
      if (ext_count == `T2_EXT_DIV - 4'h1) begin
        ext_count      <= 4'h0;
        tick.tick_ext8 <= 1'b1;
      end else begin
        ext_count      <= ext_count + 4'h1;
        tick.tick_ext8 <= 1'b0;
      end
    end else begin
      tick.tick_ext8 <= 1'b0;
    end
  end
endmodule // timer2_prescaler

// >>> tb/timer2_auto_reload_monitor.sv
// Concurrent checks on the timer's bus and interrupt ports
`timescale 1ns/100ps
`include "timer2_consts.svh"
module timer2_auto_reload_monitor #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                  i_clk,
  input wire logic                  i_rst_b,
  input wire logic                  i_ext_osc,
  input wire logic [ADDR_WIDTH-1:0] i_s_axi_awaddr,
  input wire logic                  i_s_axi_awvalid,
  input wire logic                  o_s_axi_awready,
  input wire logic [31:0]           i_s_axi_wdata,
  input wire logic [3:0]            i_s_axi_wstrb,
  input wire logic                  i_s_axi_wvalid,
  input wire logic                  o_s_axi_wready,
  input wire logic [1:0]            o_s_axi_bresp,
  input wire logic                  o_s_axi_bvalid,
  input wire logic                  i_s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] i_s_axi_araddr,
  input wire logic                  i_s_axi_arvalid,
  input wire logic                  o_s_axi_arready,
  input wire logic [31:0]           o_s_axi_rdata,
  input wire logic [1:0]            o_s_axi_rresp,
  input wire logic                  o_s_axi_rvalid,
  input wire logic                  i_s_axi_rready,
  input wire logic                  o_timer_irq,
  input wire logic                  o_irq
);
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic [2:0] aw_hist;
  logic [2:0] ar_hist;
  assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
  assign w_take  = i_s_axi_wvalid && o_s_axi_wready;
  assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
  // Interrupt lines lag the bus take by up to three edges
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_hist <= 3'h0;
      ar_hist <= 3'h0;
    end else begin
      aw_hist <= {aw_hist[1:0], aw_take || w_take};
      ar_hist <= {ar_hist[1:0], ar_take};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////
  wr_answer_a: assert property (aw_take && w_take
    |-> ##2 o_s_axi_bvalid)
    else $error("write answer missing");
  b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write answer dropped");
  wr_busy_a: assert property (o_s_axi_bvalid
    |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while busy");
  rd_answer_a: assert property (ar_take |=> o_s_axi_rvalid)
    else $error("read answer missing");
  r_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp))
    else $error("read answer changed");
  byte_wide_a: assert property (o_s_axi_rvalid
    |-> o_s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  bad_read_a: assert property (ar_take && i_s_axi_araddr > 8'h20
    |=> o_s_axi_rresp == `T2_RESP_SLVERR && o_s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  flag_hold_a: assert property ($fell(o_timer_irq) |-> |aw_hist)
    else $error("timer request cleared by itself");
  irq_hold_a: assert property ($fell(o_irq) |-> |aw_hist || |ar_hist)
    else $error("interrupt cleared by itself");
  wr_seen_c: cover property (o_s_axi_bvalid && i_s_axi_bready);
  timer_irq_c: cover property ($rose(o_timer_irq));
  irq_c: cover property ($rose(o_irq));
endmodule // timer2_auto_reload_monitor

bind timer2_auto_reload timer2_auto_reload_monitor #(
  .ADDR_WIDTH(ADDR_WIDTH)
) monitor (
  .i_clk, .i_rst_b, .i_ext_osc, .i_s_axi_awaddr, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
  .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
  .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .o_timer_irq, .o_irq
);

// >>> tb/timer2_auto_reload_bench.sv
// Self-checking bench for the auto-reload timer
`timescale 1ns/100ps
`include "timer2_consts.svh"
module timer2_auto_reload_bench;
  logic        clk;
  logic        rst_b;
  logic [1:0]  ext_cnt = 2'h0;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic        awready, wready, bvalid, arready, rvalid, timer_irq, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          err_total = 0;
  int          total_checks = 0;

  timer2_auto_reload dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_ext_osc(ext_cnt[1]),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_timer_irq(timer_irq), .o_irq(irq)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // External oscillator at a quarter of the system clock
  always @(posedge clk) ext_cnt <= ext_cnt + 2'h1;

  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // Ready is sampled on the falling edge, so the take edge is known
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_ok, w_ok, aw_t, w_t;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk);
      aw_t = !aw_ok && awready === 1'b1;
      w_t = !w_ok && wready === 1'b1;
      @(posedge clk);
      if (aw_t) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check(32'(r), 32'(`T2_RESP_OKAY));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(32'(r), 32'(`T2_RESP_OKAY));
    check(d, exp);
  endtask

  task automatic rd_range(input logic [7:0] a, input logic [7:0] lo,
                          input logic [7:0] hi);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(32'(d[7:0] >= lo && d[7:0] <= hi && d[31:8] == 24'h00_0000), 32'h1);
  endtask

  // Reads the line after the wait, off the edge, so it is settled
  task automatic irq_chk(input logic pick_irq, input logic exp);
    repeat (3) @(negedge clk);
    check(32'(pick_irq ? irq : timer_irq), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i <= 8; i++) rd_chk(8'(i * 4), 32'h0000_0000);
    axi_read(8'h24, d, r);
    check(32'(r), 32'(`T2_RESP_SLVERR));
    axi_write(8'h24, 32'h0000_00ff, r);
    check(32'(r), 32'(`T2_RESP_SLVERR));
    // One 16-bit timer on the system clock, loaded just below rollover
    wr(`T2_RLD_LO_ADDR, 32'h0000_0034);
    wr(`T2_RLD_HI_ADDR, 32'h0000_0012);
    wr(`T2_CKSEL_ADDR, 32'h0000_0010);
    wr(`T2_CNT_LO_ADDR, 32'h0000_00ff);
    wr(`T2_CNT_HI_ADDR, 32'h0000_00ff);
    rd_chk(`T2_CNT_LO_ADDR, 32'h0000_00ff);
    wr(`T2_CTRL_ADDR, 32'h0000_0004);
    rd_chk(`T2_CTRL_ADDR, 32'h0000_00c4);
    wr(`T2_CTRL_ADDR, 32'h0000_00c0);
    rd_chk(`T2_CNT_HI_ADDR, 32'h0000_0012);
    rd_range(`T2_CNT_LO_ADDR, 8'h34, 8'h60);
    axi_read(`T2_CNT_LO_ADDR, d, r);
    repeat (10) @(posedge clk);
    rd_chk(`T2_CNT_LO_ADDR, d);
    // Split mode, both bytes on the system clock, high byte held
    wr(`T2_RLD_LO_ADDR, 32'h0000_00f0);
    wr(`T2_RLD_HI_ADDR, 32'h0000_00a0);
    wr(`T2_CKSEL_ADDR, 32'h0000_0030);
    wr(`T2_CNT_HI_ADDR, 32'h0000_00ff);
    wr(`T2_CNT_LO_ADDR, 32'h0000_00fa);
    wr(`T2_CTRL_ADDR, 32'h0000_0008);
    repeat (20) @(posedge clk);
    rd_chk(`T2_CNT_HI_ADDR, 32'h0000_00ff);
    rd_chk(`T2_CTRL_ADDR, 32'h0000_0048);
    rd_range(`T2_CNT_LO_ADDR, 8'hf0, 8'hff);
    wr(`T2_CTRL_ADDR, 32'h0000_000c);
    repeat (8) @(posedge clk);
    axi_read(`T2_CTRL_ADDR, d, r);
    check(32'(d[7]), 32'h1);
    rd_range(`T2_CNT_HI_ADDR, 8'ha0, 8'hef);
    wr(`T2_CTRL_ADDR, 32'h0000_0080);
    // Timer request, then the sticky status with its mask
    wr(`T2_IRQ_EN_ADDR, 32'h0000_0001);
    irq_chk(1'b0, 1'b1);
    wr(`T2_CTRL_ADDR, 32'h0000_0040);
    irq_chk(1'b0, 1'b0);
    wr(`T2_CTRL_ADDR, 32'h0000_0060);
    irq_chk(1'b0, 1'b1);
    wr(`T2_MASK_ADDR, 32'h0000_0003);
    irq_chk(1'b1, 1'b1);
    wr(`T2_MASK_ADDR, 32'h0000_0000);
    irq_chk(1'b1, 1'b0);
    wr(`T2_MASK_ADDR, 32'h0000_0003);
    irq_chk(1'b1, 1'b1);
    rd_chk(`T2_STATUS_ADDR, 32'h0000_0003);
    irq_chk(1'b1, 1'b0);
    rd_chk(`T2_STATUS_ADDR, 32'h0000_0000);
    // Low byte on system clock / 12, then external clock / 8
    wr(`T2_CKSEL_ADDR, 32'h0000_0000);
    wr(`T2_CTRL_ADDR, 32'h0000_0008);
    wr(`T2_CNT_LO_ADDR, 32'h0000_0000);
    repeat (120) @(posedge clk);
    rd_range(`T2_CNT_LO_ADDR, 8'h09, 8'h0b);
    wr(`T2_CTRL_ADDR, 32'h0000_0009);
    wr(`T2_CNT_LO_ADDR, 32'h0000_0000);
    repeat (128) @(posedge clk);
    rd_range(`T2_CNT_LO_ADDR, 8'h03, 8'h05);
    // Frame capture set: the high byte wraps to zero, no reload
    wr(`T2_CKSEL_ADDR, 32'h0000_0030);
    wr(`T2_CNT_HI_ADDR, 32'h0000_00ff);
    wr(`T2_CTRL_ADDR, 32'h0000_001c);
    axi_read(`T2_CTRL_ADDR, d, r);
    check(32'(d[7]), 32'h1);
    rd_range(`T2_CNT_HI_ADDR, 8'h00, 8'h40);
    final_report();
  end
endmodule // timer2_auto_reload_bench
